//--- rtl/cca_pkg.sv
package cca_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] COUNT_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] MASK_OFS = 8'h0c;
   localparam logic [7:0] WDCTL_OFS = 8'h10;
   localparam logic [7:0] WDKICK_OFS = 8'h14;
   localparam logic [7:0] MODE_BASE = 8'h20;
   localparam logic [7:0] CMP_BASE = 8'h40;
   // ==========================================================
   // field positions
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_SEL_LSB = 1;
   localparam int MODE_RISE_BIT = 3;
   localparam int MODE_FALL_BIT = 4;
   localparam int WD_EN_BIT = 0;
   localparam int WD_OFS_LSB = 8;
   localparam int STS_OVF_BIT = 0;
   localparam int STS_MOD_LSB = 1;
   localparam int STS_WD_BIT = 6;
   localparam int STS_W = 7;
   // ==========================================================
   // reset values
   localparam logic [3:0] CTRL_RST = 4'h1;
   localparam logic [15:0] WDCTL_RST = 16'hff01;
   localparam logic [15:0] WD_CMP_RST = 16'hff00;
   localparam logic [4:0] MODE_RST = 5'h00;
   // ==========================================================
   // count clock divisors
   localparam int DIV_SLOW = 12;
   localparam int DIV_FAST = 4;
   localparam int DIV_OSC = 8;
   // ==========================================================
   typedef enum logic [2:0] {
      CLK_DIV12, CLK_DIV4, CLK_T0OVF, CLK_EXT, CLK_SYS, CLK_OSC8
   } cca_clk_t;
   typedef enum logic [2:0] {
      MODE_CAPTURE, MODE_SWTIMER, MODE_HSO, MODE_PWM8, MODE_PWM16, MODE_FREQ
   } cca_mode_t;
endpackage

//--- rtl/cca_top.sv
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ns
// Functional notes
// - one 16-bit time base for five modules
// - count clock chosen from six sources
// - each module runs one of six modes, except module 4 while its watchdog is on
// - module 4 adds a watchdog on time base
// - reset leaves module 4 watchdog enabled
// - module pins reach top ports, count clock stays internal
// - oscillator source is edge-detected on the system clock
module cca_top
   import cca_pkg::*;
#(
   parameter int NUM_MOD = 5,
   parameter int CNT_W = 16
) (
   input wire logic CLK_I,
   input wire logic NRST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic EXT_CNT_CLK_I,
   input wire logic EXT_OSC_I,
   input wire logic T0_OVF_I,
   input wire logic [NUM_MOD-1:0] CAP_I,
   output logic [NUM_MOD-1:0] CMP_O,
   output logic WD_RST_O,
   output logic IRQ_O
);

   // ==========================================================
   // apb slave
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rd_data;
   logic addr_ok;
   logic apb_acc;
   logic wr;
   logic [2:0] mod_idx;
   logic mod_ok;

   assign apb_acc = PSEL_I & PENABLE_I & pready_reg;
   assign wr = apb_acc & PWRITE_I;
   assign mod_idx = PADDR_I[4:2];
   assign mod_ok = (32'(mod_idx) < NUM_MOD) && (PADDR_I[1:0] == 2'b00);

   logic [3:0] ctrl_reg;
   logic [CNT_W-1:0] count_reg;
   logic [STS_W-1:0] sts_reg;
   logic [STS_W-1:0] mask_reg;
   logic [15:0] wdctl_reg;
   logic [4:0] mode_w [NUM_MOD];
   logic [CNT_W-1:0] cmp_w [NUM_MOD];

   // read decode; unmapped answers with an error and zero data
   always_comb begin
      rd_data = 32'h0000_0000;
      addr_ok = 1'b1;
      if (PADDR_I == CTRL_OFS) begin
         rd_data[3:0] = ctrl_reg;
      end else if (PADDR_I == COUNT_OFS) begin
         rd_data[CNT_W-1:0] = count_reg;
      end else if (PADDR_I == STATUS_OFS) begin
         rd_data[STS_W-1:0] = sts_reg;
      end else if (PADDR_I == MASK_OFS) begin
         rd_data[STS_W-1:0] = mask_reg;
      end else if (PADDR_I == WDCTL_OFS) begin
         rd_data[15:0] = wdctl_reg;
      end else if (PADDR_I == WDKICK_OFS) begin
         rd_data = 32'h0000_0000;
      end else if (PADDR_I[7:5] == MODE_BASE[7:5] && mod_ok) begin
         rd_data[4:0] = mode_w[mod_idx];
      end else if (PADDR_I[7:5] == CMP_BASE[7:5] && mod_ok) begin
         rd_data[CNT_W-1:0] = cmp_w[mod_idx];
      end else begin
         addr_ok = 1'b0;
      end
   end

   // one wait state: ready rises on the second access cycle
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= PSEL_I & PENABLE_I & ~pready_reg;
         pslverr_reg <= PSEL_I & PENABLE_I & ~pready_reg & ~addr_ok;
         if (PSEL_I & PENABLE_I & ~pready_reg & ~PWRITE_I) begin
            prdata_reg <= rd_data;
         end else begin
            prdata_reg <= 32'h0000_0000;
         end
      end
   end

   assign PREADY_O = pready_reg;
   assign PSLVERR_O = pslverr_reg;
   assign PRDATA_O = prdata_reg;

   logic wr_ctrl;
   logic wr_count;
   logic wr_sts;
   logic wr_mask;
   logic wr_wdctl;
   logic kick;
   assign wr_ctrl = wr && PADDR_I == CTRL_OFS;
   assign wr_count = wr && PADDR_I == COUNT_OFS;
   assign wr_sts = wr && PADDR_I == STATUS_OFS;
   assign wr_mask = wr && PADDR_I == MASK_OFS;
   assign wr_wdctl = wr && PADDR_I == WDCTL_OFS;
   assign kick = wr && PADDR_I == WDKICK_OFS;

   // ==========================================================
   // control registers
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ctrl_reg <= CTRL_RST; // counter runs from reset so the watchdog can fire
         mask_reg <= '0;
         wdctl_reg <= WDCTL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= PWDATA_I[3:0];
         end
         if (wr_mask) begin
            mask_reg <= PWDATA_I[STS_W-1:0];
         end
         if (wr_wdctl) begin
            wdctl_reg <= PWDATA_I[15:0];
         end
      end
   end

   // ==========================================================
   // count clock sources
   logic [3:0] presc_reg;
   logic ext_prev_reg;
   logic osc_prev_reg;
   logic [2:0] osc_div_reg;
   logic tick_slow;
   logic tick_fast;
   logic ext_edge;
   logic osc_edge;
   logic osc_tick;
   logic tick;
   logic run;
   cca_clk_t sel;

   assign run = ctrl_reg[CTRL_RUN_BIT];
   assign sel = cca_clk_t'(ctrl_reg[CTRL_SEL_LSB +: 3]);
   assign tick_slow = presc_reg == 4'(DIV_SLOW - 1);
   assign tick_fast = presc_reg[1:0] == 2'(DIV_FAST - 1); // 12 is a multiple of 4
   assign ext_edge = EXT_CNT_CLK_I & ~ext_prev_reg;
   assign osc_edge = EXT_OSC_I & ~osc_prev_reg;
   assign osc_tick = osc_edge && osc_div_reg == 3'(DIV_OSC - 1);

   // prescaler and edge detectors run always, only the mux follows sel
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         presc_reg <= 4'h0;
         ext_prev_reg <= 1'b0;
         osc_prev_reg <= 1'b0;
         osc_div_reg <= 3'h0;
      end else begin
         presc_reg <= tick_slow ? 4'h0 : presc_reg + 4'h1;
         ext_prev_reg <= EXT_CNT_CLK_I;
         osc_prev_reg <= EXT_OSC_I;
         if (osc_edge) begin
            osc_div_reg <= osc_div_reg + 3'h1;
         end
      end
   end

   // source select; the oscillator only needs to be slower than half CLK_I
   always_comb begin
      case (sel)
         CLK_DIV12: tick = tick_slow;
         CLK_DIV4: tick = tick_fast;
         CLK_T0OVF: tick = T0_OVF_I;
         CLK_EXT: tick = ext_edge;
         CLK_SYS: tick = 1'b1;
         CLK_OSC8: tick = osc_tick;
         default: tick = 1'b0;
      endcase
      tick = tick & run;
   end

   // ==========================================================
   // time base
   logic ovf;
   assign ovf = tick && count_reg == '1;

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         count_reg <= '0;
      end else if (wr_count) begin
         count_reg <= PWDATA_I[CNT_W-1:0];
      end else if (tick) begin
         count_reg <= count_reg + CNT_W'(1);
      end
   end

   // ==========================================================
   // capture/compare modules
   logic [NUM_MOD-1:0] mod_evt;
   logic [NUM_MOD-1:0] out_next;
   logic wd_en;
   logic wd_fire;
   assign wd_en = wdctl_reg[WD_EN_BIT];

   genvar gi;
   generate
      for (gi = 0; gi < NUM_MOD; gi++) begin : g_mod
         logic [4:0] mode_reg;
         logic [CNT_W-1:0] cmp_reg;
         logic cap_prev_reg;
         logic out_reg;
         logic is_wd;
         logic wr_mode;
         logic wr_cmp;
         logic edge_hit;
         logic hit;
         logic hit8;
         cca_mode_t md;

         assign is_wd = (gi == 4) && wd_en;
         assign md = cca_mode_t'(mode_reg[2:0]);
         assign wr_mode = wr && PADDR_I[7:5] == MODE_BASE[7:5] && mod_ok
            && 32'(mod_idx) == gi && !is_wd;
         assign wr_cmp = wr && PADDR_I[7:5] == CMP_BASE[7:5] && mod_ok
            && 32'(mod_idx) == gi && !is_wd;
         assign edge_hit = (mode_reg[MODE_RISE_BIT] & CAP_I[gi] & ~cap_prev_reg)
            | (mode_reg[MODE_FALL_BIT] & ~CAP_I[gi] & cap_prev_reg);
         assign hit = tick && count_reg == cmp_reg;
         assign hit8 = tick && count_reg[7:0] == cmp_reg[7:0];
         assign mode_w[gi] = mode_reg;
         assign cmp_w[gi] = cmp_reg;

         // mode register and input edge history
         always_ff @(posedge CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
               mode_reg <= MODE_RST;
               cap_prev_reg <= 1'b0;
            end else begin
               cap_prev_reg <= CAP_I[gi];
               if (wr_mode) begin
                  mode_reg <= PWDATA_I[4:0];
               end
            end
         end

         // compare value: software, capture, watchdog reload, freq step
         always_ff @(posedge CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
               cmp_reg <= (gi == 4) ? WD_CMP_RST : '0;
            end else if (wr_cmp) begin
               cmp_reg <= PWDATA_I[CNT_W-1:0];
            end else if (is_wd && kick) begin
               cmp_reg[15:8] <= count_reg[15:8] + wdctl_reg[WD_OFS_LSB +: 8];
               cmp_reg[7:0] <= count_reg[7:0];
            end else if (!is_wd && md == MODE_CAPTURE && edge_hit) begin
               cmp_reg <= count_reg;
            end else if (!is_wd && md == MODE_FREQ && hit8) begin
               cmp_reg[7:0] <= cmp_reg[7:0] + cmp_reg[15:8];
            end
         end

         // output level and module event per mode
         always_comb begin
            out_next[gi] = out_reg;
            mod_evt[gi] = 1'b0;
            if (!is_wd) begin
               case (md)
                  MODE_CAPTURE: mod_evt[gi] = edge_hit;
                  MODE_SWTIMER: mod_evt[gi] = hit;
                  MODE_HSO: begin
                     mod_evt[gi] = hit;
                     out_next[gi] = out_reg ^ hit;
                  end
                  MODE_PWM8: begin
                     mod_evt[gi] = hit8;
                     out_next[gi] = count_reg[7:0] >= cmp_reg[7:0];
                  end
                  MODE_PWM16: begin
                     mod_evt[gi] = hit;
                     out_next[gi] = count_reg >= cmp_reg;
                  end
                  MODE_FREQ: out_next[gi] = out_reg ^ hit8;
                  default: out_next[gi] = 1'b0;
               endcase
            end
         end

         always_ff @(posedge CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
               out_reg <= 1'b0;
            end else begin
               out_reg <= out_next[gi];
            end
         end

         assign CMP_O[gi] = out_reg;
      end
   endgenerate

   // a full 16-bit match after the last reload means software missed it
   assign wd_fire = wd_en && tick && count_reg == cmp_w[4];

   // ==========================================================
   // status, interrupt and watchdog reset
   logic [STS_W-1:0] sts_set;
   logic [STS_W-1:0] sts_clr;
   logic wd_rst_reg;
   logic irq_reg;

   assign sts_set = {wd_fire, mod_evt[NUM_MOD-1:0], ovf};
   assign sts_clr = wr_sts ? PWDATA_I[STS_W-1:0] : '0;

   // set beats a same-cycle write-one-to-clear
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         sts_reg <= '0;
         irq_reg <= 1'b0;
         wd_rst_reg <= 1'b0;
      end else begin
         sts_reg <= (sts_reg & ~sts_clr) | sts_set;
         irq_reg <= |(((sts_reg & ~sts_clr) | sts_set) & mask_reg);
         wd_rst_reg <= wd_fire;
      end
   end

   assign IRQ_O = irq_reg;
   assign WD_RST_O = wd_rst_reg;

endmodule // cca_top

//--- testbench/cca_asserts.sv
`timescale 1ns/1ns
module cca_asserts (
   input wire logic CLK_I,
   input wire logic NRST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   input wire logic WD_RST_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   // ==========================================================
   // bus answer timing
   property p_rdy;
      $rose(PENABLE_I) && PSEL_I |=> PREADY_O;
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready late");
   property p_rdy_one;
      PREADY_O |=> !PREADY_O;
   endproperty
   a_rdy_one: assert property (p_rdy_one) else $error("ready held");
   property p_rdy_cause;
      PREADY_O |-> $past(PSEL_I, 2) && $past(PENABLE_I);
   endproperty
   a_rdy_cause: assert property (p_rdy_cause) else $error("ready unasked");
   // ==========================================================
   // decode: module index above four is refused
   property p_err_hi;
      $rose(PENABLE_I) && PSEL_I && PADDR_I >= 8'h54 |=> PSLVERR_O;
   endproperty
   a_err_hi: assert property (p_err_hi) else $error("no slverr");
   property p_err_lo;
      $rose(PENABLE_I) && PSEL_I && PADDR_I <= 8'h14 && PADDR_I[1:0] == 2'b00
         |=> !PSLVERR_O;
   endproperty
   a_err_lo: assert property (p_err_lo) else $error("false slverr");
   property p_rd_idle;
      !PREADY_O |-> PRDATA_O == 32'h0 && !PSLVERR_O;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("data outside answer");
   // 16-bit time base, so nothing lives above bit 15
   property p_rd_hi;
      PREADY_O |-> PRDATA_O[31:16] == 16'h0;
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("upper data set");
   property p_wd_one;
      WD_RST_O |=> !WD_RST_O;
   endproperty
   a_wd_one: assert property (p_wd_one) else $error("watchdog pulse long");
endmodule // cca_asserts

bind cca_top cca_asserts chk_u (.CLK_I(CLK_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
   .PSLVERR_O(PSLVERR_O), .WD_RST_O(WD_RST_O));

//--- testbench/cca_top_tb.sv
`timescale 1ns/1ns
module cca_top_tb;
   import cca_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] d; logic e;} cca_row_t;
   // ==========================================================
   // stimulus and design
   logic clk, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] padr = 8'h00;
   logic [31:0] pwd = 32'h0, prd, rdat;
   logic prdy, perr, rerr, irq, wdr;
   logic [4:0] cap = 5'h00, cmp;
   logic [7:0] cyc = 8'h00;
   logic [31:0] exp_tick [6] = '{32'd8, 32'd24, 32'd24, 32'd12, 32'd96, 32'd3};
   int fails = 0, n_tests = 0, k;
   cca_row_t rows [9] = '{'{CTRL_OFS, {28'h0, CTRL_RST}, 1'b0},
      '{STATUS_OFS, 32'h0, 1'b0}, '{MASK_OFS, 32'h0, 1'b0},
      '{WDCTL_OFS, {16'h0, WDCTL_RST}, 1'b0}, '{MODE_BASE, {27'h0, MODE_RST}, 1'b0},
      '{CMP_BASE + 8'h10, {16'h0, WD_CMP_RST}, 1'b0},
      '{8'h18, 32'h0, 1'b1}, '{8'h34, 32'h0, 1'b1}, '{8'h54, 32'h0, 1'b1}};
   cca_top dut_u (.CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
      .PSLVERR_O(perr), .EXT_CNT_CLK_I(cyc[2]), .EXT_OSC_I(cyc[1]),
      .T0_OVF_I(cyc[1:0] == 2'b00), .CAP_I(cap), .CMP_O(cmp), .WD_RST_O(wdr), .IRQ_O(irq));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // free-running sources so every count clock choice sees edges
   always @(posedge clk) begin
      cyc <= cyc + 8'h01;
   end
   // ==========================================================
   // tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] x, input string n);
      n_tests++;
      if (s !== x) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, x, s);
      end
   endtask
   // one transfer; waits on ready, bounded so a dead slave cannot hang us
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (prdy !== 1'b1 && k < 20);
      rdat = prd;
      rerr = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (k >= 20) fails++;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input string n);
      apb(1'b0, a, 32'h0);
      chk(rdat, x, n);
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 32'h0);
         chk({31'h0, rerr}, {31'h0, rows[i].e}, "slverr");
         if (!rows[i].e) chk(rdat, rows[i].d, "reset value");
      end
      $display("test reset values done");
      // watchdog live from reset: bring count up to its compare
      wr(CTRL_OFS, 32'h9);
      wr(COUNT_OFS, 32'hfef0);
      k = 0;
      while (wdr !== 1'b1 && k < 60) begin
         @(posedge clk);
         k++;
      end
      chk({31'h0, wdr}, 32'h1, "watchdog fire");
      rd_chk(STATUS_OFS, 32'h40, "watchdog status");
      wr(CMP_BASE + 8'h10, 32'h1234);
      rd_chk(CMP_BASE + 8'h10, 32'hff00, "cmp4 locked");
      $display("test watchdog done");
      // overflow into interrupt, then write-one clear
      wr(WDCTL_OFS, 32'h0);
      wr(STATUS_OFS, 32'h7f);
      wr(MASK_OFS, 32'h1);
      wr(COUNT_OFS, 32'hfff0);
      repeat (30) @(posedge clk);
      chk({31'h0, irq}, 32'h1, "irq set");
      rd_chk(STATUS_OFS, 32'h1, "overflow flag");
      wr(STATUS_OFS, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0, "irq clear");
      $display("test overflow done");
      // window edges add a few ticks, hence the tolerance band
      for (int s = 0; s < 6; s++) begin
         wr(CTRL_OFS, 32'(s * 2));
         wr(COUNT_OFS, 32'h0);
         wr(CTRL_OFS, 32'(s * 2 + 1));
         repeat (96) @(posedge clk);
         wr(CTRL_OFS, 32'(s * 2));
         apb(1'b0, COUNT_OFS, 32'h0);
         chk((rdat + 1 >= exp_tick[s] && rdat <= exp_tick[s] + 5) ? exp_tick[s] : rdat,
            exp_tick[s], "tick count");
      end
      $display("test count sources done");
      // capture with the counter held, so the value is exact
      wr(COUNT_OFS, 32'h1234);
      wr(MODE_BASE, 32'h08);
      wr(STATUS_OFS, 32'h7f);
      cap <= 5'h01;
      @(posedge clk);
      cap <= 5'h00;
      repeat (3) @(posedge clk);
      rd_chk(CMP_BASE, 32'h1234, "capture");
      rd_chk(STATUS_OFS, 32'h2, "capture event");
      $display("test capture done");
      // timer, toggle and frequency modes over one short sweep from zero
      wr(MODE_BASE + 8'h04, 32'h1);
      wr(CMP_BASE + 8'h04, 32'h10);
      wr(MODE_BASE + 8'h08, 32'h2);
      wr(CMP_BASE + 8'h08, 32'h10);
      wr(MODE_BASE + 8'h0c, 32'h5);
      wr(CMP_BASE + 8'h0c, 32'h4005);
      wr(COUNT_OFS, 32'h0);
      wr(STATUS_OFS, 32'h7f);
      wr(CTRL_OFS, 32'h9);
      repeat (40) @(posedge clk);
      wr(CTRL_OFS, 32'h8);
      chk({27'h0, cmp}, 32'h0c, "toggle outputs");
      rd_chk(CMP_BASE + 8'h0c, 32'h4045, "freq step");
      rd_chk(STATUS_OFS, 32'h0c, "timer events");
      $display("test timer modes done");
      // pwm levels follow a held count, so they can be set exactly
      wr(MODE_BASE + 8'h04, 32'h3);
      wr(CMP_BASE + 8'h04, 32'h80);
      wr(MODE_BASE + 8'h08, 32'h4);
      wr(CMP_BASE + 8'h08, 32'h200);
      wr(COUNT_OFS, 32'h190);
      @(posedge clk);
      chk({27'h0, cmp}, 32'h0a, "pwm low byte");
      wr(COUNT_OFS, 32'h300);
      @(posedge clk);
      chk({27'h0, cmp}, 32'h0c, "pwm full word");
      $display("test pwm modes done");
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd_chk(WDCTL_OFS, {16'h0, WDCTL_RST}, "wd after reset");
      $display("test second reset done");
      // a kick moves the compare well past the near expiry
      wr(CTRL_OFS, 32'h9);
      wr(COUNT_OFS, 32'hfef0);
      wr(WDKICK_OFS, 32'h0);
      k = 0;
      repeat (40) begin
         @(posedge clk);
         if (wdr !== 1'b0) k++;
      end
      chk(k, 32'h0, "kick holds off");
      rd_chk(STATUS_OFS, 32'h0, "no watchdog status");
      $display("test kick done");
      final_report();
   end
   initial begin
      #(20000 * 100);
      fails++;
      final_report();
   end
endmodule // cca_top_tb
